// ===== design/adc_readout_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB data, one register per aligned word
// Notes: Definitions only
`ifndef ADC_READOUT_CFG_SVH
`define ADC_READOUT_CFG_SVH
`define RD_RESULT_BITS 16
`define RD_OFS_CTRL 12'h000
`define RD_OFS_STATUS 12'h004
`define RD_OFS_IRQ_EN 12'h008
`define RD_OFS_IRQ_CLR 12'h00C
`define RD_OFS_RESULT 12'h010
`define RD_CTRL_RUN 0
`define RD_CTRL_TAG_EN 1
`define RD_CTRL_MANUAL_TRIG 9
`define RD_CTRL_CONVERSION_CLOCK_INTERNAL 10
`define RD_RST_TAG_EN 1'b0
`define RD_RST_MANUAL_TRIG 1'b1
`define RD_RST_CONVERSION_CLOCK_INTERNAL 1'b1
`define RD_ST_DONE 0
`define RD_ST_FRAME_END 1
`define RD_ST_QUIET_HIT 2
`define RD_ST_COLLISION 3
`define RD_ST_BITS 4
`define RD_CLK_PERIOD_NS 100
`define RD_QUIET_NS 20
`define RD_QUIET_CYC ((`RD_QUIET_NS + `RD_CLK_PERIOD_NS - 1) / `RD_CLK_PERIOD_NS)
`define RD_EOS_CCLKS 3
`define RD_AUTO_START_CLKS 4
`endif

// ===== design/adc_readout_pkg.sv
// Purpose: Types shared by the readout block
// Assumes: Constants come from adc_readout_cfg.svh
// Notes: State of each module is one packed struct
`include "adc_readout_cfg.svh"

package adc_readout_pkg;
    typedef enum logic [1:0] {
        TRG_IDLE = 2'b00,
        TRG_EOS_WAIT = 2'b01,
        TRG_EOC_LOW = 2'b10,
        TRG_START_WAIT = 2'b11
    } trig_state_t;

    typedef logic [`RD_RESULT_BITS-1:0] result_t;

    typedef struct packed {
        logic tagEnable;
        logic manualTrigger;
        logic cclkInternal;
        logic [`RD_ST_BITS-1:0] status;
        logic [`RD_ST_BITS-1:0] irqEnable;
        logic [31:0] rdata;
        logic eocPrev;
        logic framePrev;
        logic sclkPrev;
        logic convPrev;
        result_t holdInput;
        logic tagInput;
        result_t holdOutput;
        logic tagOutput;
        logic pending;
        logic allOnes;
        logic frameActive;
        logic frameTag;
        logic conversion_clock;
        logic [7:0] oscCount;
        trig_state_t trig;
        logic [1:0] trigCount;
        logic [3:0] quietCount;
        logic samplingEnd;
        logic convStart;
    } readout_state_t;

    typedef struct packed {
        logic [`RD_RESULT_BITS:0] word;
        logic fill;
        logic [4:0] bitCount;
    } shifter_state_t;
endpackage : adc_readout_pkg

// ===== design/readout_if.sv
// Purpose: Carrier between readout control and the SDO shifter
// Assumes: Both ends on sys_clk
// Notes: Word is result bits then tag slot
`include "adc_readout_cfg.svh"

interface readout_if;
    logic load;
    logic fillOnes;
    logic step;
    logic [`RD_RESULT_BITS:0] loadWord;
    logic sdo;
    logic [4:0] bitCount;
    modport ctrl (output load, fillOnes, step, loadWord, input sdo, bitCount);
    modport shift (input load, fillOnes, step, loadWord, output sdo, bitCount);
endinterface : readout_if

// ===== design/pin_sync.sv
// Purpose: Two-stage synchroniser for asynchronous pins
// Assumes: Synchronous active-high reset
// Notes: Only stage two is visible outside
module pin_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    always_comb begin
        next_st.stage1 = pinIn;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '{stage1: RESET_VAL, stage2: RESET_VAL};
        end else begin
            st <= next_st;
        end
    end

    assign pinOut = st.stage2;
endmodule : pin_sync

// ===== design/sdo_shifter.sv
// Purpose: SDO shift register, MSB first, filler after the word
// Assumes: Load and step come from the control side on sys_clk
// Notes: Count saturates so a long frame keeps the filler
module sdo_shifter
    import adc_readout_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control side
    readout_if.shift bus
);
    shifter_state_t st;
    shifter_state_t next_st;

    always_comb begin
        next_st = st;
        if (bus.load) begin
            next_st.word = bus.loadWord;
            next_st.fill = bus.fillOnes;
            next_st.bitCount = 5'h00;
        end else if (bus.step) begin
            next_st.word = {st.word[`RD_RESULT_BITS-1:0], st.fill};
            if (st.bitCount != 5'h1F) begin
                next_st.bitCount = st.bitCount + 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bus.sdo = st.word[`RD_RESULT_BITS];
    assign bus.bitCount = st.bitCount;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_zero_tail: assert property (st.bitCount >= 5'h11 && !st.fill |-> bus.sdo == 1'b0)
        else $error("Filler after tag slot is not zero");
    a_shift_order: assert property (bus.step && !bus.load |=> bus.sdo == $past(st.word[15]))
        else $error("Shift did not advance one bit");
endmodule : sdo_shifter

// ===== design/adc_result_serial_readout.sv
// Purpose: Result hold register and SDO serial readout with APB control
// Assumes: sys_clk 10 MHz; link pins asynchronous, sampled by pin_sync
// Notes: SDO changes after SCLK falls; host samples on SCLK rise
`include "adc_readout_cfg.svh"

module adc_result_serial_readout
    import adc_readout_pkg::*;
#(
    parameter int OSC_DIV = 2
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter core
    input wire logic eoc,
    input wire logic [`RD_RESULT_BITS-1:0] resultIn,
    input wire logic tagIn,
    output logic conversionClock,
    output logic samplingEnd,
    output logic conversionStartPulse,
    // Serial link pins
    input wire logic frameSelectN,
    input wire logic sclk,
    input wire logic conversionStartN,
    output logic sdoOut,
    output logic sdoOe,
    // Interrupt
    output logic irq
);
    localparam readout_state_t RESET_ST = '{
        tagEnable: `RD_RST_TAG_EN,
        manualTrigger: `RD_RST_MANUAL_TRIG,
        cclkInternal: `RD_RST_CONVERSION_CLOCK_INTERNAL,
        framePrev: 1'b1,
        convPrev: 1'b1,
        allOnes: 1'b1,
        trig: TRG_IDLE,
        default: '0
    };

    readout_state_t st;
    readout_state_t next_st;
    readout_if bus ();

    logic [2:0] pinSync;
    logic frameLvl;
    logic sclkLvl;
    logic convLvl;
    logic frameFall;
    logic frameRise;
    logic sclkRise;
    logic sclkFall;
    logic convFall;
    logic eocRise;
    logic oscTick;
    logic cclkTick;
    logic quietHit;
    logic setup;
    logic access;
    logic wrAccess;
    logic mapped;
    logic softReset;
    result_t heldNext;
    logic tagNext;
    logic [`RD_ST_BITS-1:0] clearBits;
    logic [`RD_ST_BITS-1:0] events;

    function automatic logic regHit(input logic [11:0] addr, input logic [11:0] ofs);
        return addr == ofs;
    endfunction : regHit

    // Frame and start idle high so no false edge after reset
    pin_sync #(
        .WIDTH(3),
        .RESET_VAL(3'h5)
    ) u_pin_sync (
        .clk(sys_clk),
        .rst(rst),
        .pinIn({frameSelectN, sclk, conversionStartN}),
        .pinOut(pinSync)
    );

    sdo_shifter u_sdo_shifter (
        .clk(sys_clk),
        .rst(rst),
        .bus(bus.shift)
    );

    assign frameLvl = pinSync[2];
    assign sclkLvl = pinSync[1];
    assign convLvl = pinSync[0];
    assign frameFall = st.framePrev & ~frameLvl;
    assign frameRise = ~st.framePrev & frameLvl;
    assign sclkRise = ~st.sclkPrev & sclkLvl;
    assign sclkFall = st.sclkPrev & ~sclkLvl;
    assign convFall = st.convPrev & ~convLvl;
    assign eocRise = eoc & ~st.eocPrev;
    assign oscTick = st.oscCount == 8'(OSC_DIV - 1);
    assign cclkTick = ~st.conversion_clock & (st.cclkInternal ? oscTick : sclkRise);

    // Edge seen within the quiet window is only flagged, not blocked
    assign quietHit = (sclkRise | sclkFall) & ~frameLvl & (st.quietCount != 4'h0);

    // Bus access
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wrAccess = access & pwrite;
    assign mapped = regHit(paddr, `RD_OFS_CTRL) | regHit(paddr, `RD_OFS_STATUS)
        | regHit(paddr, `RD_OFS_IRQ_EN) | regHit(paddr, `RD_OFS_IRQ_CLR)
        | regHit(paddr, `RD_OFS_RESULT);
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata = st.rdata;
    assign softReset = wrAccess & regHit(paddr, `RD_OFS_CTRL) & ~pwdata[`RD_CTRL_RUN];
    assign clearBits = (wrAccess && regHit(paddr, `RD_OFS_IRQ_CLR)) ? pwdata[`RD_ST_BITS-1:0] : 4'h0;

    assign events[`RD_ST_DONE] = eocRise;
    assign events[`RD_ST_FRAME_END] = frameRise & st.frameActive;
    assign events[`RD_ST_QUIET_HIT] = quietHit;
    assign events[`RD_ST_COLLISION] = frameFall & eocRise;

    // Pending result is taken only by a frame opening after done
    assign heldNext = st.pending ? st.holdInput : st.holdOutput;
    assign tagNext = st.pending ? st.tagInput : st.tagOutput;

    assign bus.load = frameFall;
    assign bus.fillOnes = st.allOnes;
    assign bus.step = sclkFall & st.frameActive & ~frameFall;
    assign bus.loadWord = st.allOnes ? {(`RD_RESULT_BITS + 1){1'b1}}
        : {heldNext, st.tagEnable & tagNext};

    always_comb begin
        next_st = st;
        next_st.eocPrev = eoc;
        next_st.framePrev = frameLvl;
        next_st.sclkPrev = sclkLvl;
        next_st.convPrev = convLvl;
        next_st.samplingEnd = 1'b0;
        next_st.convStart = 1'b0;

        if (setup) begin
            case (paddr)
                `RD_OFS_CTRL: begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.rdata[`RD_CTRL_RUN] = 1'b1;
                    next_st.rdata[`RD_CTRL_TAG_EN] = st.tagEnable;
                    next_st.rdata[`RD_CTRL_MANUAL_TRIG] = st.manualTrigger;
                    next_st.rdata[`RD_CTRL_CONVERSION_CLOCK_INTERNAL] = st.cclkInternal;
                end
                `RD_OFS_STATUS: next_st.rdata = {28'h0000000, st.status};
                `RD_OFS_IRQ_EN: next_st.rdata = {28'h0000000, st.irqEnable};
                `RD_OFS_RESULT: next_st.rdata = {15'h0000, st.tagOutput, st.holdOutput};
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end

        if (wrAccess && regHit(paddr, `RD_OFS_CTRL)) begin
            next_st.tagEnable = pwdata[`RD_CTRL_TAG_EN];
            next_st.manualTrigger = pwdata[`RD_CTRL_MANUAL_TRIG];
            next_st.cclkInternal = pwdata[`RD_CTRL_CONVERSION_CLOCK_INTERNAL];
        end
        if (wrAccess && regHit(paddr, `RD_OFS_IRQ_EN)) begin
            next_st.irqEnable = pwdata[`RD_ST_BITS-1:0];
        end

        // Set wins over a clear in the same cycle
        next_st.status = (st.status & ~clearBits) | events;

        // Frame open: present the held word
        if (frameFall) begin
            next_st.frameActive = 1'b1;
            next_st.holdOutput = heldNext;
            next_st.tagOutput = tagNext;
            next_st.pending = 1'b0;
            next_st.frameTag = st.allOnes | (st.tagEnable & tagNext);
        end
        if (frameRise) begin
            next_st.frameActive = 1'b0;
            if (st.frameActive) begin
                next_st.allOnes = 1'b0;
            end
        end

        // Done after frame handling so a coinciding result is not lost
        if (eocRise) begin
            next_st.holdInput = resultIn;
            next_st.tagInput = tagIn;
            next_st.pending = 1'b1;
        end

        // Conversion clock from the divided system clock or SCLK
        next_st.oscCount = oscTick ? 8'h00 : st.oscCount + 8'h01;
        if (st.cclkInternal ? oscTick : sclkRise) begin
            next_st.conversion_clock = ~st.conversion_clock;
        end

        case (st.trig)
            TRG_IDLE: begin
                if (eocRise) begin
                    next_st.trig = TRG_EOS_WAIT;
                    next_st.trigCount = 2'h0;
                end
            end
            TRG_EOS_WAIT: begin
                if (cclkTick) begin
                    if (st.trigCount == 2'(`RD_EOS_CCLKS - 1)) begin
                        next_st.samplingEnd = 1'b1;
                        next_st.trig = TRG_EOC_LOW;
                    end else begin
                        next_st.trigCount = st.trigCount + 2'h1;
                    end
                end
            end
            TRG_EOC_LOW: begin
                if (!eoc) begin
                    next_st.trig = TRG_START_WAIT;
                    next_st.trigCount = 2'h0;
                end
            end
            TRG_START_WAIT: begin
                if (oscTick) begin
                    if (st.trigCount == 2'(`RD_AUTO_START_CLKS - 1)) begin
                        next_st.convStart = 1'b1;
                        next_st.trig = TRG_IDLE;
                    end else begin
                        next_st.trigCount = st.trigCount + 2'h1;
                    end
                end
            end
            default: next_st.trig = TRG_IDLE;
        endcase

        // Manual trigger overrides the automatic sequence
        if (st.manualTrigger) begin
            next_st.trig = TRG_IDLE;
            next_st.samplingEnd = convFall;
            next_st.convStart = convFall;
        end

        // Quiet window starting at end of sampling
        if (next_st.samplingEnd) begin
            next_st.quietCount = 4'(`RD_QUIET_CYC);
        end else if (st.quietCount != 4'h0) begin
            next_st.quietCount = st.quietCount - 4'h1;
        end

        // Software reset: next frame shows ones, stale result dropped
        if (softReset) begin
            next_st.allOnes = 1'b1;
            next_st.pending = 1'b0;
            next_st.trig = TRG_IDLE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st <= RESET_ST;
        end else begin
            st <= next_st;
        end
    end

    assign sdoOut = bus.sdo & st.frameActive;
    assign sdoOe = st.frameActive;
    assign conversionClock = st.conversion_clock;
    assign samplingEnd = st.samplingEnd;
    assign conversionStartPulse = st.convStart;
    assign irq = |(st.status & st.irqEnable);

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_frame_open;
        frameFall && !st.allOnes;
    endsequence
    sequence s_msb_out;
        sdoOe && sdoOut == st.holdOutput[15];
    endsequence

    a_load_on_done: assert property (eocRise |=> st.holdInput == $past(resultIn))
        else $error("Result not captured at done");
    a_hold_at_frame: assert property (!$stable(st.holdOutput) |-> $past(frameFall))
        else $error("Hold output changed outside a frame fall");
    a_eos_auto: assert property (st.trig == TRG_EOS_WAIT && cclkTick && st.trigCount == 2'h2
        && !st.manualTrigger |=> st.samplingEnd)
        else $error("End of sampling missed third conversion clock");
    a_prev_result: assert property (frameFall && !st.pending |=> $stable(st.holdOutput))
        else $error("Frame before done did not keep previous result");
    a_msb_first: assert property (s_frame_open |=> s_msb_out)
        else $error("MSB not on SDO after frame fall");
    a_sdo_release: assert property (frameRise |=> !sdoOe ##1 !sdoOe)
        else $error("SDO still driven after frame select rose");
    a_ones_after_reset: assert property (st.allOnes && sdoOe |-> sdoOut)
        else $error("First frame after reset not all ones");
    a_tag_slot: assert property (sdoOe && bus.bitCount == 5'h10 |-> sdoOut == st.frameTag)
        else $error("Tag slot wrong at seventeenth clock");
    a_conversion_clock_half: assert property (!st.cclkInternal && sclkRise |=> st.conversion_clock != $past(st.conversion_clock))
        else $error("Conversion clock not at half SCLK");
    a_auto_start: assert property (st.trig == TRG_START_WAIT && oscTick && st.trigCount == 2'h3
        && !st.manualTrigger |=> st.convStart ##1 !st.convStart)
        else $error("Auto start not after four internal clocks");
endmodule : adc_result_serial_readout

// ===== testbench/host_link_model.sv
// Purpose: Host side of the serial link: frame select, SCLK, SDO capture
// Assumes: SCLK period 800 ns, idle low and still between frames
// Notes: Pin edges sit off the system clock phase on purpose
module host_link_model (
    // Link pins
    output logic frameSelectN,
    output logic sclk,
    input wire logic sdoOut,
    input wire logic sdoOe
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        frameSelectN = 1'b1;
        sclk = 1'b0;
    end

    // Callers start frames well clear of conversion done and sampling end
    task automatic frame(input int n, output logic [31:0] bits, output logic oeIn, output logic oeOff);
        bits = '0;
        oeIn = 1'b1;
        #37 frameSelectN = 1'b0;
        for (int i = 0; i < n; i++) begin
            #400 sclk = 1'b1;
            // Host samples on the rising edge
            bits = {bits[30:0], sdoOut};
            oeIn = oeIn & sdoOe;
            #400 sclk = 1'b0;
        end
        #400 frameSelectN = 1'b1;
        #400 oeOff = sdoOe;
    endtask : frame
endmodule : host_link_model

// ===== testbench/adc_result_serial_readout_test.sv
// Purpose: Self-checking bench for the result readout block
// Assumes: APB with pready from the block, host model on the link pins
// Notes: Auto trigger timing is left to the design's own assertions
`include "adc_readout_cfg.svh"

module adc_result_serial_readout_test
    import adc_readout_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, eoc, tagIn;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [15:0] resultIn;
    logic conversionClock, samplingEnd, conversionStartPulse, frameSelectN, sclk;
    logic conversionStartN, sdoOut, sdoOe, irq, e, seenEnd, seenStart;
    int n_fail = 0;
    int comparisons = 0;
    int nCclk = 0, nEnd = 0, nStart = 0, mark0, mark1, mark2;
    logic cclkSeen = 1'b0;

    adc_result_serial_readout #(.OSC_DIV(2)) uut (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .eoc(eoc), .resultIn(resultIn), .tagIn(tagIn), .conversionClock(conversionClock),
        .samplingEnd(samplingEnd), .conversionStartPulse(conversionStartPulse),
        .frameSelectN(frameSelectN), .sclk(sclk), .conversionStartN(conversionStartN),
        .sdoOut(sdoOut), .sdoOe(sdoOe), .irq(irq)
    );

    host_link_model host (
        .frameSelectN(frameSelectN), .sclk(sclk), .sdoOut(sdoOut), .sdoOe(sdoOe)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Pulse and toggle counters; scenarios compare differences
    always @(posedge sys_clk) begin
        cclkSeen <= conversionClock;
        if (conversionClock !== cclkSeen) begin
            nCclk <= nCclk + 1;
        end
        if (samplingEnd === 1'b1) begin
            nEnd <= nEnd + 1;
        end
        if (conversionStartPulse === 1'b1) begin
            nStart <= nStart + 1;
        end
    end

    task automatic end_sim();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] x;
        logic er;
        apb(1'b1, a, wd, x, er);
        chk("write error", 32'h0, {31'h0, er});
    endtask : wr

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] x;
        logic er;
        apb(1'b0, a, 32'h0, x, er);
        chk(what, exp, x & mask);
        chk("read error", 32'h0, {31'h0, er});
    endtask : rd_chk

    // Result and tag valid at the done rise, done held a few cycles
    task automatic convert(input logic [15:0] v, input logic t);
        @(posedge sys_clk);
        resultIn <= v;
        tagIn <= t;
        eoc <= 1'b1;
        repeat (4) @(posedge sys_clk);
        eoc <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask : convert

    task automatic frame_chk(input string what, input int n, input logic [31:0] exp);
        logic [31:0] bits;
        logic oeIn, oeOff;
        host.frame(n, bits, oeIn, oeOff);
        chk(what, exp, bits);
        chk("sdo driven in frame", 32'h1, {31'h0, oeIn});
        chk("sdo released after frame", 32'h0, {31'h0, oeOff});
        @(posedge sys_clk);
    endtask : frame_chk

    initial begin
        #2000000;
        n_fail++;
        end_sim();
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        eoc = 1'b0;
        resultIn = 16'h0000;
        tagIn = 1'b0;
        conversionStartN = 1'b1;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk("ctrl reset", `RD_OFS_CTRL, 32'hFFFFFFFF, 32'h00000601);
        rd_chk("status reset", `RD_OFS_STATUS, 32'hFFFFFFFF, 32'h0);
        rd_chk("irq enable reset", `RD_OFS_IRQ_EN, 32'hFFFFFFFF, 32'h0);
        apb(1'b0, 12'h020, 32'h0, d, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, d);
        frame_chk("first frame", 16, 32'h0000FFFF);
        convert(16'hA5C3, 1'b1);
        frame_chk("untagged word", 19, {13'h0, 16'hA5C3, 3'b000});
        wr(`RD_OFS_CTRL, 32'h00000603);
        convert(16'h1234, 1'b1);
        frame_chk("tagged word", 18, {14'h0, 16'h1234, 2'b10});
        frame_chk("short frame", 4, 32'h00000001);
        convert(16'hC001, 1'b0);
        rd_chk("held before frame", `RD_OFS_RESULT, 32'h0000FFFF, 32'h00001234);
        frame_chk("new result", 16, 32'h0000C001);
        rd_chk("held after frame", `RD_OFS_RESULT, 32'h0000FFFF, 32'h0000C001);
        // Interrupt: clear, enable done, raise, clear, mask
        wr(`RD_OFS_IRQ_CLR, 32'h0000000F);
        wr(`RD_OFS_IRQ_EN, 32'h00000001);
        @(posedge sys_clk);
        chk("irq idle", 32'h0, {31'h0, irq});
        convert(16'h8000, 1'b0);
        chk("irq raised", 32'h1, {31'h0, irq});
        rd_chk("status done", `RD_OFS_STATUS, 32'h00000001, 32'h1);
        wr(`RD_OFS_IRQ_CLR, 32'h00000001);
        @(posedge sys_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(`RD_OFS_IRQ_EN, 32'h00000000);
        convert(16'hFFFF, 1'b0);
        chk("irq masked", 32'h0, {31'h0, irq});
        // Manual trigger: start pin fall gives sampling end and start pulse
        seenEnd = 1'b0;
        seenStart = 1'b0;
        conversionStartN <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk);
            seenEnd = seenEnd | (samplingEnd === 1'b1);
            seenStart = seenStart | (conversionStartPulse === 1'b1);
        end
        conversionStartN <= 1'b1;
        chk("sampling end seen", 32'h1, {31'h0, seenEnd});
        chk("start pulse seen", 32'h1, {31'h0, seenStart});
        // Software reset: the next frame shows all ones again
        wr(`RD_OFS_CTRL, 32'h00000602);
        repeat (4) @(posedge sys_clk);
        frame_chk("frame after soft reset", 16, 32'h0000FFFF);
        // Auto trigger: exactly one sampling end and one start per conversion
        wr(`RD_OFS_CTRL, 32'h00000401);
        mark0 = nEnd;
        mark1 = nStart;
        convert(16'h0F0F, 1'b0);
        repeat (20) @(posedge sys_clk);
        chk("auto sampling end", 32'h1, 32'(nEnd - mark0));
        chk("auto start", 32'h1, 32'(nStart - mark1));
        // Serial clock as conversion clock: one toggle per SCLK rise
        wr(`RD_OFS_CTRL, 32'h00000203);
        repeat (4) @(posedge sys_clk);
        mark2 = nCclk;
        frame_chk("sclk clocked frame", 8, 32'h0000000F);
        chk("conversion clock toggles", 32'h8, 32'(nCclk - mark2));
        end_sim();
    end
endmodule : adc_result_serial_readout_test
